// >>> ssq_pkg.sv
/*
 * shared constants and types for the slow-clock supply sequencer.
 * assumes all logic runs on the always-on slow domain clock.
 */
package ssq_pkg;
    localparam logic [7:0] SSQ_KEY_VALUE = 8'ha5;
    localparam int SSQ_RC_SETTLE_CYC = 5;
    localparam int SSQ_XTAL_START_CYC = 16;
    localparam int SSQ_CNT_W = 12;
    localparam int SSQ_SMP_32 = 32;
    localparam int SSQ_SMP_256 = 256;
    localparam int SSQ_SMP_2048 = 2048;
    localparam logic [2:0] SSQ_SMPL_OFF = 3'h0;
    localparam logic [2:0] SSQ_SMPL_CONT = 3'h1;
    localparam logic [2:0] SSQ_SMPL_32 = 3'h2;
    localparam logic [2:0] SSQ_SMPL_256 = 3'h3;
    localparam logic [3:0] SSQ_THRESH_RST = 4'h0;
    localparam logic [2:0] SSQ_SMPL_RST = 3'h0;
    typedef enum logic [2:0] {
        SSQ_PWR_SETTLE = 3'b000,
        SSQ_PWR_REG_ON = 3'b001,
        SSQ_PWR_RUN = 3'b011
    } ssq_pwr_t;
    typedef enum logic [2:0] {
        SSQ_CK_RC = 3'b000,
        SSQ_CK_PINS = 3'b001,
        SSQ_CK_WAIT = 3'b011,
        SSQ_CK_SWAP = 3'b010,
        SSQ_CK_XTAL = 3'b110
    } ssq_ck_t;
endpackage

// >>> ssq_clk_if.sv
/*
 * carrier between the sequencer and its glitch-free clock switch.
 * assumes both ends share the slow domain clock and reset.
 */
`timescale 1ns/1ps
interface ssq_clk_if;
    logic sel_xtal;
    logic rc_clk;
    logic xtal_clk;
    logic clk_out;
    logic on_xtal;
    modport seq (output sel_xtal, output rc_clk, output xtal_clk, input clk_out, input on_xtal);
    modport sw (input sel_xtal, input rc_clk, input xtal_clk, output clk_out, output on_xtal);
endinterface

// >>> ssq_clk_switch.sv
/*
 * glitch-free two-source selector for the slow clock output.
 * assumes both source levels are sampled on sys_clk_i and change slower.
 */
`timescale 1ns/1ps
module ssq_clk_switch (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    ssq_clk_if.sw cif
);
    logic rc_en_r;
    logic xt_en_r;
    logic out_r;
    logic on_xtal_r;
    // a source is dropped only while its level is low, so no pulse is cut short
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rc_en_r <= 1'b1;
            xt_en_r <= 1'b0;
        end else begin
            if (cif.sel_xtal && rc_en_r && !cif.rc_clk) begin
                rc_en_r <= 1'b0;
            end else if (cif.sel_xtal && !rc_en_r && !xt_en_r && !cif.xtal_clk) begin
                xt_en_r <= 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_r <= 1'b0;
            on_xtal_r <= 1'b0;
        end else begin
            out_r <= (rc_en_r & cif.rc_clk) | (xt_en_r & cif.xtal_clk);
            on_xtal_r <= xt_en_r;
        end
    end
    assign cif.clk_out = out_r;
    assign cif.on_xtal = on_xtal_r;
endmodule

// >>> ssq_top.sv
/*
 * supply sequencer of the always-on slow domain: power-up, clock source
 * changeover, duty-cycled supply monitor and core reset generation.
 * assumes sys_clk_i is the slow clock and rst_b_i comes from the
 * zero-power power-on cell; oscillator clocks are sampled as plain levels.
 */
//
// Contract
// - hold all supply-control logic in reset while the power-on cell is low.
// - count 5 slow cycles after power-on release before enabling regulator.
// - release core reset after core voltage good for one cycle post enable.
// - at power-up only RC oscillator enabled and selected; crystal off.
// - keyed crystal command: route pins, enable crystal, wait, switch, RC off.
// - source changeover produces no glitch or truncated pulse.
// - set clock source flag only when crystal switch sequence has finished.
// - no way back to RC once crystal selected, except supply power-down.
// - drive monitor threshold from the monitor threshold field.
// - enable monitor one cycle of 32, 256, 2048, or continuously.
// - update live monitor level at each measurement or every cycle.
// - sticky detect flag set on detection, cleared by status read.
// - raise interrupt while detect flag set and irq enable high.
// - monitor detection with reset enable asserts core reset at once.
// - keep monitor reset asserted until supply reported valid again.
// - with enable and regulator on, reset when core voltage lost over one cycle.
// - core voltage reset lasts a cycle minimum and while voltage stays low.
// - set core reset flag on a core-voltage-loss reset.
// - write protect blocks control, monitor mode and supply mode writes.
// - control writes act only with key 0xa5; others discarded entirely.
`timescale 1ns/1ps
module ssq_top #(
    parameter int RC_SETTLE_CYC = ssq_pkg::SSQ_RC_SETTLE_CYC,
    parameter int XTAL_START_CYC = ssq_pkg::SSQ_XTAL_START_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_key_i,
    input wire logic crystal_select_cmd_i,
    input wire logic mon_mode_wr_i,
    input wire logic [3:0] monitor_threshold_i,
    input wire logic [2:0] monitor_sample_rate_i,
    input wire logic monitor_reset_enable_i,
    input wire logic monitor_irq_enable_i,
    input wire logic supply_mode_wr_i,
    input wire logic osc_bypass_enable_i,
    input wire logic core_por_reset_enable_i,
    input wire logic write_protect_enable_i,
    input wire logic status_rd_i,
    input wire logic core_voltage_ok_i,
    input wire logic monitor_detect_i,
    input wire logic rc_clk_i,
    input wire logic xtal_clk_i,
    output logic slow_clock_out_o,
    output logic rc_osc_en_o,
    output logic xtal_osc_en_o,
    output logic xtal_bypass_o,
    output logic xtal_pins_route_o,
    output logic regulator_en_o,
    output logic core_reset_n_o,
    output logic monitor_en_o,
    output logic [3:0] monitor_threshold_o,
    output logic [2:0] monitor_sample_rate_o,
    output logic monitor_reset_enable_o,
    output logic monitor_irq_enable_o,
    output logic osc_bypass_enable_o,
    output logic core_por_reset_enable_o,
    output logic clock_source_flag_o,
    output logic monitor_live_level_o,
    output logic monitor_detect_flag_o,
    output logic core_por_reset_flag_o,
    output logic irq_o
);
    import ssq_pkg::*;

    ssq_clk_if cif();
    ssq_clk_switch u_sw (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .cif(cif)
    );

    ssq_pwr_t pwr_r;
    ssq_ck_t ck_r;
    logic [SSQ_CNT_W-1:0] pwr_cnt_r;
    logic [SSQ_CNT_W-1:0] ck_cnt_r;
    logic [SSQ_CNT_W-1:0] smp_cnt_r;
    logic [3:0] thr_r;
    logic [2:0] smpl_r;
    logic mrst_en_r;
    logic mirq_en_r;
    logic bypass_r;
    logic bod_en_r;
    logic smp_slot_r;
    logic live_r;
    logic det_flag_r;
    logic bod_flag_r;
    logic irq_r;
    logic mon_rst_r;
    logic bod_lost_r;
    logic bod_rst_r;
    logic core_rst_n_r;
    logic wr_ok;
    logic xtal_go;
    logic meas;
    logic mon_hit;
    logic bod_hit;
    logic [SSQ_CNT_W-1:0] smp_period;

    // every register below resets from the power-on cell
    assign wr_ok = !write_protect_enable_i;
    assign xtal_go = ctrl_wr_i && wr_ok && (ctrl_key_i == SSQ_KEY_VALUE)
                     && crystal_select_cmd_i;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            thr_r <= SSQ_THRESH_RST;
            smpl_r <= SSQ_SMPL_RST;
            mrst_en_r <= 1'b0;
            mirq_en_r <= 1'b0;
        end else if (mon_mode_wr_i && wr_ok) begin
            thr_r <= monitor_threshold_i;
            smpl_r <= monitor_sample_rate_i;
            mrst_en_r <= monitor_reset_enable_i;
            mirq_en_r <= monitor_irq_enable_i;
        end
    end

    // bypass is frozen once the crystal sequence has begun
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bypass_r <= 1'b0;
            bod_en_r <= 1'b0;
        end else if (supply_mode_wr_i && wr_ok) begin
            if (ck_r == SSQ_CK_RC) begin
                bypass_r <= osc_bypass_enable_i;
            end
            bod_en_r <= core_por_reset_enable_i;
        end
    end

    // power-up: settle the rc oscillator, then run the regulator
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwr_r <= SSQ_PWR_SETTLE;
            pwr_cnt_r <= '0;
        end else begin
            case (pwr_r)
                SSQ_PWR_SETTLE: begin
                    if (pwr_cnt_r == SSQ_CNT_W'(RC_SETTLE_CYC - 1)) begin
                        pwr_r <= SSQ_PWR_REG_ON;
                    end else begin
                        pwr_cnt_r <= pwr_cnt_r + 1'b1;
                    end
                end
                SSQ_PWR_REG_ON: begin
                    if (core_voltage_ok_i) begin
                        pwr_r <= SSQ_PWR_RUN;
                    end
                end
                default: begin
                    pwr_r <= SSQ_PWR_RUN;
                end
            endcase
        end
    end

    // crystal changeover; the xtal state has no exit
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ck_r <= SSQ_CK_RC;
            ck_cnt_r <= '0;
        end else begin
            case (ck_r)
                SSQ_CK_RC: begin
                    if (xtal_go) begin
                        ck_r <= SSQ_CK_PINS;
                    end
                end
                SSQ_CK_PINS: begin
                    ck_r <= SSQ_CK_WAIT;
                    ck_cnt_r <= '0;
                end
                SSQ_CK_WAIT: begin
                    if (ck_cnt_r == SSQ_CNT_W'(XTAL_START_CYC - 1)) begin
                        ck_r <= SSQ_CK_SWAP;
                    end else begin
                        ck_cnt_r <= ck_cnt_r + 1'b1;
                    end
                end
                SSQ_CK_SWAP: begin
                    if (cif.on_xtal) begin
                        ck_r <= SSQ_CK_XTAL;
                    end
                end
                default: begin
                    ck_r <= SSQ_CK_XTAL;
                end
            endcase
        end
    end

    assign cif.sel_xtal = (ck_r == SSQ_CK_SWAP) || (ck_r == SSQ_CK_XTAL);
    assign cif.rc_clk = rc_clk_i;
    assign cif.xtal_clk = xtal_clk_i;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rc_osc_en_o <= 1'b1;
            xtal_osc_en_o <= 1'b0;
            xtal_pins_route_o <= 1'b0;
            clock_source_flag_o <= 1'b0;
            regulator_en_o <= 1'b0;
            slow_clock_out_o <= 1'b0;
        end else begin
            xtal_pins_route_o <= (ck_r != SSQ_CK_RC);
            xtal_osc_en_o <= (ck_r != SSQ_CK_RC) && (ck_r != SSQ_CK_PINS);
            rc_osc_en_o <= (ck_r != SSQ_CK_XTAL);
            clock_source_flag_o <= (ck_r == SSQ_CK_XTAL);
            regulator_en_o <= (pwr_r != SSQ_PWR_SETTLE);
            slow_clock_out_o <= cif.clk_out;
        end
    end

    always_comb begin
        if (smpl_r == SSQ_SMPL_32) begin
            smp_period = SSQ_CNT_W'(SSQ_SMP_32 - 1);
        end else if (smpl_r == SSQ_SMPL_256) begin
            smp_period = SSQ_CNT_W'(SSQ_SMP_256 - 1);
        end else begin
            smp_period = SSQ_CNT_W'(SSQ_SMP_2048 - 1);
        end
    end

    // codes from 4 up take the 2048 period; off leaves the monitor idle
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            smp_cnt_r <= '0;
            smp_slot_r <= 1'b0;
        end else begin
            if (smp_cnt_r >= smp_period) begin
                smp_cnt_r <= '0;
            end else begin
                smp_cnt_r <= smp_cnt_r + 1'b1;
            end
            smp_slot_r <= (smpl_r == SSQ_SMPL_CONT)
                          || ((smpl_r != SSQ_SMPL_OFF) && (smp_cnt_r >= smp_period));
        end
    end

    assign meas = smp_slot_r;
    assign mon_hit = meas && monitor_detect_i;
    assign bod_hit = bod_en_r && (pwr_r == SSQ_PWR_RUN) && !core_voltage_ok_i && bod_lost_r;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            live_r <= 1'b0;
            det_flag_r <= 1'b0;
            bod_flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            if (meas) begin
                live_r <= monitor_detect_i;
            end
            // a detection in the read cycle survives the clear
            if (mon_hit) begin
                det_flag_r <= 1'b1;
            end else if (status_rd_i) begin
                det_flag_r <= 1'b0;
            end
            if (bod_hit) begin
                bod_flag_r <= 1'b1;
            end
            irq_r <= (det_flag_r || mon_hit) && mirq_en_r;
        end
    end

    // core reset sources; each holds until its own supply recovers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mon_rst_r <= 1'b0;
            bod_lost_r <= 1'b0;
            bod_rst_r <= 1'b0;
            core_rst_n_r <= 1'b0;
        end else begin
            if (mrst_en_r && mon_hit) begin
                mon_rst_r <= 1'b1;
            end else if (meas && !monitor_detect_i) begin
                mon_rst_r <= 1'b0;
            end
            bod_lost_r <= !core_voltage_ok_i && (pwr_r == SSQ_PWR_RUN);
            if (bod_hit) begin
                bod_rst_r <= 1'b1;
            end else if (core_voltage_ok_i) begin
                bod_rst_r <= 1'b0;
            end
            // power-up release only; later core loss resets only through the enabled path
            core_rst_n_r <= core_rst_n_r || ((pwr_r == SSQ_PWR_RUN) && core_voltage_ok_i);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_reset_n_o <= 1'b0;
        end else begin
            core_reset_n_o <= core_rst_n_r && !(mrst_en_r && mon_hit)
                              && !mon_rst_r && !bod_rst_r && !bod_hit;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            monitor_en_o <= 1'b0;
            monitor_threshold_o <= SSQ_THRESH_RST;
            monitor_sample_rate_o <= SSQ_SMPL_RST;
            monitor_reset_enable_o <= 1'b0;
            monitor_irq_enable_o <= 1'b0;
            osc_bypass_enable_o <= 1'b0;
            xtal_bypass_o <= 1'b0;
            core_por_reset_enable_o <= 1'b0;
            monitor_live_level_o <= 1'b0;
            monitor_detect_flag_o <= 1'b0;
            core_por_reset_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            monitor_en_o <= (smpl_r == SSQ_SMPL_CONT)
                            || ((smpl_r != SSQ_SMPL_OFF) && (smp_cnt_r >= smp_period));
            monitor_threshold_o <= thr_r;
            monitor_sample_rate_o <= smpl_r;
            monitor_reset_enable_o <= mrst_en_r;
            monitor_irq_enable_o <= mirq_en_r;
            osc_bypass_enable_o <= bypass_r;
            xtal_bypass_o <= bypass_r && (ck_r != SSQ_CK_RC);
            core_por_reset_enable_o <= bod_en_r;
            monitor_live_level_o <= live_r;
            monitor_detect_flag_o <= det_flag_r;
            core_por_reset_flag_o <= bod_flag_r;
            irq_o <= irq_r;
        end
    end
endmodule

// >>> ssq_top_assertions.sv
/* port checks for the slow-clock supply sequencer top.
   assumes bind onto ssq_top; one clock domain, async active-low reset. */
`timescale 1ns/1ps
module ssq_top_assertions #(
    parameter int RC_SETTLE_CYC = 5
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic status_rd_i,
    input wire logic mon_mode_wr_i,
    input wire logic write_protect_enable_i,
    input wire logic monitor_detect_i,
    input wire logic core_voltage_ok_i,
    input wire logic regulator_en_o,
    input wire logic core_reset_n_o,
    input wire logic rc_osc_en_o,
    input wire logic xtal_osc_en_o,
    input wire logic xtal_pins_route_o,
    input wire logic clock_source_flag_o,
    input wire logic slow_clock_out_o,
    input wire logic monitor_en_o,
    input wire logic [3:0] monitor_threshold_o,
    input wire logic monitor_reset_enable_o,
    input wire logic monitor_irq_enable_o,
    input wire logic monitor_detect_flag_o,
    input wire logic core_por_reset_flag_o,
    input wire logic core_por_reset_enable_o,
    input wire logic irq_o
);
    logic [3:0] since_rel_r;
    // saturates so a long run never wraps back into the settle window
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_rel_r <= 4'h0;
        end else if (since_rel_r != 4'hf) begin
            since_rel_r <= since_rel_r + 4'h1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_reg_wait;
        since_rel_r < 4'(RC_SETTLE_CYC) |-> !regulator_en_o;
    endproperty
    a_reg_wait: assert property (p_reg_wait) else $error("regulator enabled early");
    property p_core_rel;
        $rose(core_reset_n_o) |-> regulator_en_o && $past(core_voltage_ok_i);
    endproperty
    a_core_rel: assert property (p_core_rel) else $error("core reset released early");
    property p_rc_first;
        !clock_source_flag_o |-> rc_osc_en_o;
    endproperty
    a_rc_first: assert property (p_rc_first) else $error("rc off before switch");
    property p_src_flag;
        clock_source_flag_o |-> xtal_osc_en_o && xtal_pins_route_o && !rc_osc_en_o;
    endproperty
    a_src_flag: assert property (p_src_flag) else $error("source flag state wrong");
    property p_no_back;
        clock_source_flag_o |=> clock_source_flag_o;
    endproperty
    a_no_back: assert property (p_no_back) else $error("returned to rc");
    property p_glitch;
        $rose(slow_clock_out_o) |=> slow_clock_out_o [*2];
    endproperty
    a_glitch: assert property (p_glitch) else $error("short clock pulse");
    property p_thr;
        $changed(monitor_threshold_o) |-> ($past(mon_mode_wr_i) && !$past(write_protect_enable_i))
            || ($past(mon_mode_wr_i, 2) && !$past(write_protect_enable_i, 2));
    endproperty
    a_thr: assert property (p_thr) else $error("threshold changed unwritten");
    property p_sticky;
        $fell(monitor_detect_flag_o) |-> $past(status_rd_i) || $past(status_rd_i, 2)
            || $past(status_rd_i, 3);
    endproperty
    a_sticky: assert property (p_sticky) else $error("detect flag lost");
    property p_irq;
        (monitor_detect_flag_o && monitor_irq_enable_o) [*2] |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_mon_rst;
        (monitor_en_o && monitor_detect_i) ##1 monitor_reset_enable_o
            |-> ##[0:2] !core_reset_n_o;
    endproperty
    a_mon_rst: assert property (p_mon_rst) else $error("no monitor reset");
    property p_core_loss;
        (core_por_reset_enable_o && regulator_en_o && !core_voltage_ok_i) [*4] |-> !core_reset_n_o;
    endproperty
    a_core_loss: assert property (p_core_loss) else $error("no core loss reset");
    property p_por_flag;
        $rose(core_por_reset_flag_o) |-> !$past(core_voltage_ok_i, 2) || !$past(core_voltage_ok_i, 3);
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("por flag without loss");
    c_xtal: cover property (clock_source_flag_o);
    c_irq: cover property (irq_o);
    c_por: cover property (core_por_reset_flag_o);
endmodule
bind ssq_top ssq_top_assertions #(.RC_SETTLE_CYC(RC_SETTLE_CYC)) i_ssq_top_assertions (.*);

// >>> ssq_osc_model.sv
/* far side: rc and crystal oscillators plus core regulator good signal.
   assumes enables come from the sequencer; core_drop_i forces a core loss. */
`timescale 1ns/1ps
module ssq_osc_model (
    input wire logic sys_clk_i,
    input wire logic rc_osc_en_i,
    input wire logic xtal_osc_en_i,
    input wire logic regulator_en_i,
    input wire logic core_drop_i,
    output logic rc_clk_o = 1'b0,
    output logic xtal_clk_o = 1'b0,
    output logic core_voltage_ok_o = 1'b0
);
    int rc_ph = 0;
    int xt_ph = 0;
    int reg_cnt = 0;
    // a stopped oscillator stands low and restarts on a low phase, so its first pulse is whole
    always @(posedge sys_clk_i) begin
        rc_ph <= rc_osc_en_i ? rc_ph + 1 : 0;
        xt_ph <= xtal_osc_en_i ? xt_ph + 1 : 0;
        rc_clk_o <= rc_osc_en_i && ((rc_ph / 4) % 2 == 1);
        xtal_clk_o <= xtal_osc_en_i && ((xt_ph / 3) % 2 == 1);
        reg_cnt <= regulator_en_i ? reg_cnt + 1 : 0;
        core_voltage_ok_o <= regulator_en_i && reg_cnt >= 3 && !core_drop_i;
    end
endmodule

// >>> ssq_top_tb.sv
/* self-checking bench for the supply sequencer top.
   assumes ssq_pkg and the osc model are compiled first. */
`timescale 1ns/1ps
module ssq_top_tb;
    import ssq_pkg::*;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, ctrl_wr_i = 1'b0, crystal_select_cmd_i = 1'b0;
    logic mon_mode_wr_i = 1'b0, monitor_reset_enable_i = 1'b0, monitor_irq_enable_i = 1'b0;
    logic supply_mode_wr_i = 1'b0, osc_bypass_enable_i = 1'b0, core_por_reset_enable_i = 1'b0;
    logic write_protect_enable_i = 1'b0, status_rd_i = 1'b0, monitor_detect_i = 1'b0;
    logic [7:0] ctrl_key_i = 8'h00;
    logic [3:0] monitor_threshold_i = 4'h0, monitor_threshold_o;
    logic [2:0] monitor_sample_rate_i = 3'h0, monitor_sample_rate_o;
    logic core_voltage_ok_i, rc_clk_i, xtal_clk_i, core_drop = 1'b0;
    logic slow_clock_out_o, rc_osc_en_o, xtal_osc_en_o, xtal_bypass_o, xtal_pins_route_o;
    logic regulator_en_o, core_reset_n_o, monitor_en_o, monitor_reset_enable_o;
    logic monitor_irq_enable_o, osc_bypass_enable_o, core_por_reset_enable_o, irq_o;
    logic clock_source_flag_o, monitor_live_level_o, monitor_detect_flag_o, core_por_reset_flag_o;
    int fail_count = 0;
    int comparisons = 0;
    int n;
    ssq_top #(.XTAL_START_CYC(4)) i_ssq_top (.*);
    ssq_osc_model i_ssq_osc_model (.sys_clk_i(sys_clk_i), .rc_osc_en_i(rc_osc_en_o),
        .xtal_osc_en_i(xtal_osc_en_o), .regulator_en_i(regulator_en_o), .core_drop_i(core_drop),
        .rc_clk_o(rc_clk_i), .xtal_clk_o(xtal_clk_i), .core_voltage_ok_o(core_voltage_ok_i));
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    // one-cycle pulse on {ctrl, mon mode, supply mode, status read}
    task automatic strobe(input logic [3:0] s);
        @(posedge sys_clk_i);
        #1 {ctrl_wr_i, mon_mode_wr_i, supply_mode_wr_i, status_rd_i} = s;
        @(posedge sys_clk_i);
        #1 {ctrl_wr_i, mon_mode_wr_i, supply_mode_wr_i, status_rd_i} = 4'h0;
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        fail_count++;
        print_verdict();
    end
    initial begin
        cyc(3);
        rst_b_i = 1'b1;
        check({rc_osc_en_o, core_reset_n_o, regulator_en_o, clock_source_flag_o}, 4'h8);
        for (n = 0; n < 20 && regulator_en_o !== 1'b1; n++) cyc(1);
        check(16'(n), 16'(SSQ_RC_SETTLE_CYC + 1));
        check(core_reset_n_o, 1'b0);
        for (n = 0; n < 20 && core_reset_n_o !== 1'b1; n++) cyc(1);
        check({core_reset_n_o, core_voltage_ok_i}, 2'h3);
        $display("test power-up done");
        monitor_threshold_i = 4'ha;
        monitor_sample_rate_i = SSQ_SMPL_32;
        {monitor_reset_enable_i, monitor_irq_enable_i} = 2'h3;
        write_protect_enable_i = 1'b1;
        strobe(4'h4);
        {ctrl_key_i, crystal_select_cmd_i} = {8'ha5, 1'b1};
        strobe(4'h8);
        cyc(30);
        check({monitor_threshold_o, xtal_pins_route_o}, 5'h00);
        write_protect_enable_i = 1'b0;
        ctrl_key_i = 8'h5a;
        strobe(4'h8);
        cyc(30);
        check(xtal_pins_route_o, 1'b0);
        {osc_bypass_enable_i, core_por_reset_enable_i} = 2'h3;
        strobe(4'h2); // bypass set ahead of the crystal command
        strobe(4'h4);
        cyc(2);
        check({monitor_threshold_o, monitor_sample_rate_o, monitor_reset_enable_o,
            monitor_irq_enable_o, osc_bypass_enable_o, core_por_reset_enable_o}, 16'h052f);
        ctrl_key_i = 8'ha5;
        strobe(4'h8);
        for (n = 0; n < 300 && clock_source_flag_o !== 1'b1; n++) cyc(1);
        check({clock_source_flag_o, rc_osc_en_o, xtal_osc_en_o, xtal_bypass_o}, 4'hb);
        strobe(4'h8);
        cyc(20);
        check({clock_source_flag_o, rc_osc_en_o}, 2'h2);
        for (n = 0; n < 20 && slow_clock_out_o !== 1'b1; n++) cyc(1);
        check(slow_clock_out_o, 1'b1);
        $display("test clock switch done");
        for (n = 0; n < 80 && monitor_en_o !== 1'b1; n++) cyc(1);
        cyc(1);
        for (n = 1; n < 80 && monitor_en_o !== 1'b1; n++) cyc(1);
        check(16'(n), 16'(SSQ_SMP_32));
        monitor_detect_i = 1'b1;
        for (n = 0; n < 80 && monitor_detect_flag_o !== 1'b1; n++) cyc(1);
        cyc(2);
        check({monitor_detect_flag_o, irq_o, core_reset_n_o, monitor_live_level_o}, 4'hd);
        monitor_detect_i = 1'b0;
        strobe(4'h1);
        cyc(2);
        check({monitor_detect_flag_o, irq_o}, 2'h0);
        for (n = 0; n < 80 && core_reset_n_o !== 1'b1; n++) cyc(1);
        check({core_reset_n_o, monitor_live_level_o}, 2'h2);
        monitor_sample_rate_i = SSQ_SMPL_CONT;
        monitor_reset_enable_i = 1'b0;
        strobe(4'h4);
        cyc(3);
        monitor_detect_i = 1'b1;
        cyc(3);
        check({monitor_en_o, monitor_live_level_o, core_reset_n_o}, 3'h7);
        monitor_detect_i = 1'b0;
        cyc(3);
        check({monitor_en_o, monitor_live_level_o}, 2'h2);
        $display("test monitor done");
        core_drop = 1'b1;
        cyc(6);
        check({core_reset_n_o, core_por_reset_flag_o}, 2'h1);
        cyc(10);
        check(core_reset_n_o, 1'b0);
        core_drop = 1'b0;
        for (n = 0; n < 20 && core_reset_n_o !== 1'b1; n++) cyc(1);
        check(core_reset_n_o, 1'b1);
        $display("test core loss done");
        rst_b_i = 1'b0;
        cyc(2);
        check({rc_osc_en_o, clock_source_flag_o, core_reset_n_o, irq_o}, 4'h8);
        rst_b_i = 1'b1;
        cyc(20);
        check({rc_osc_en_o, regulator_en_o}, 2'h3);
        core_drop = 1'b1;
        cyc(6);
        check(core_reset_n_o, 1'b1);
        core_drop = 1'b0;
        $display("test second reset done");
        print_verdict();
    end
endmodule
